// File: common/lpr_pkg.sv
// constants, encodings and register map of the led pwm serial register port
// Operation
// (RULE_01) read without address starts at last pointer
// (RULE_02) single random read: one byte, nack, stop
// (RULE_03) combined format: write address, restart, read
// (RULE_04) write stores consecutive registers, each byte acked
// (RULE_05) host programs peak current code 08h only
// (RULE_06) host loads enable 2Ah or 02h
// (RULE_07) log dimming reduces all enabled outputs equally
// (RULE_08) log code 00h none, FFh fully off
// (RULE_09) linear mode subtracts global code from duty
// (RULE_10) linear: zero unchanged, excess forces zero
// (RULE_11) host writes only defined register addresses
// (RULE_12) bus ignored while chip enable low
// (RULE_13) pointer loaded on write, incremented per byte
// (RULE_14) mode input selects log or linear dimming
`default_nettype none
package lpr_pkg;
    // clocking of the controller end
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          SCL_PERIOD_NS = 10000;
    localparam int          QUARTER_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [7:0]  QUARTER_LAST  = 8'(QUARTER_CYC - 1);

    // target address of the device end, value of our own making
    localparam logic [6:0]  TARGET_ADDR   = 7'h33;
    localparam logic        RW_READ       = 1'b1;

    // register map
    localparam logic [7:0]  REG_CH1_PEAK  = 8'h00;
    localparam logic [7:0]  REG_CH2_PEAK  = 8'h01;
    localparam logic [7:0]  REG_CH3_PEAK  = 8'h02;
    localparam logic [7:0]  REG_ENABLE    = 8'h03;
    localparam logic [7:0]  REG_GLOBAL_DIM = 8'h04;
    localparam logic [7:0]  PEAK_RESET    = 8'h00;
    localparam logic [5:0]  ENABLE_RESET  = 6'h00;
    localparam logic [7:0]  DIM_RESET     = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;
    localparam logic [7:0]  PTR_RESET     = 8'h00;

    // enable register layout: per channel sense bit then output bit
    localparam int          NUM_CH        = 3;
    localparam int          EN_SENSE_LSB  = 0;
    localparam int          EN_PWM_LSB    = 1;
    localparam int          EN_STRIDE     = 2;

    // dimming codes
    localparam logic [7:0]  DIM_OFF       = 8'hff;
    localparam logic [7:0]  DUTY_ZERO     = 8'h00;

    // bit counter marks within a nine clock byte slot
    localparam logic [3:0]  BIT_ACK       = 4'h8;
    localparam logic [3:0]  BIT_DONE      = 4'h9;
    localparam logic [3:0]  BIT_FIRST     = 4'h1;

    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_ADDR = 3'b001,
        DS_REG  = 3'b010,
        DS_WR   = 3'b011,
        DS_RD   = 3'b100,
        DS_WAIT = 3'b101
    } lpr_dev_state_e;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'b000,
        HS_START  = 3'b001,
        HS_ADDR   = 3'b010,
        HS_REG    = 3'b011,
        HS_WDATA  = 3'b100,
        HS_RSTART = 3'b101,
        HS_RDATA  = 3'b110,
        HS_STOP   = 3'b111
    } lpr_host_state_e;

    typedef enum logic [1:0] {
        OP_WRITE    = 2'b00,
        OP_READ_CUR = 2'b01,
        OP_READ_AT  = 2'b10
    } lpr_op_e;
endpackage
`default_nettype wire

// File: common/lpr_if.sv
// two wire serial link between controller and target, open drain data
`timescale 1ns/10ps
`default_nettype none
interface lpr_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // wired and of both drivers, released line reads high
    assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// File: src/lpr_target.sv
// target end: serial register port, control registers and global dimming
`timescale 1ns/10ps
`default_nettype none
module lpr_target (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    lpr_if.dev                       bus,
    input  wire logic                i_chip_en,
    input  wire logic                i_dim_linear,
    input  wire logic [2:0][7:0]     i_user_duty,
    output logic      [2:0][7:0]     o_pwm_code,
    output logic      [2:0]          o_pwm_enable,
    output logic      [2:0]          o_sense_enable,
    output logic      [2:0][7:0]     o_peak_current,
    output logic      [7:0]          o_global_dim,
    output logic      [7:0]          o_reg_ptr
);
    lpr_pkg::lpr_dev_state_e state_ff;
    logic        scl_q_ff;
    logic        sda_q_ff;
    logic [3:0]  bit_cnt_ff;
    logic [7:0]  shift_ff;
    logic        rw_ff;
    logic        sda_oe_ff;
    logic [7:0]  ptr_ff;
    logic [2:0][7:0] peak_ff;
    logic [5:0]  enable_ff;
    logic [7:0]  dim_ff;
    logic [7:0]  rd_value;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        at_ack;
    logic        at_done;
    logic        reg_load;
    logic        wr_stb;
    logic        rd_inc;

    // previous line levels for edge and condition detection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= bus.scl;
            sda_q_ff <= bus.sda;
        end
    end

    assign scl_rise  = bus.scl & ~scl_q_ff;
    assign scl_fall  = ~bus.scl & scl_q_ff;
    assign start_det = bus.scl & scl_q_ff & sda_q_ff & ~bus.sda;
    assign stop_det  = bus.scl & scl_q_ff & ~sda_q_ff & bus.sda;
    assign at_ack    = (bit_cnt_ff == lpr_pkg::BIT_ACK);
    assign at_done   = (bit_cnt_ff == lpr_pkg::BIT_DONE);

    // register strobes, all gated by chip enable
    assign reg_load = i_chip_en & scl_fall & at_ack & (state_ff == lpr_pkg::DS_REG); // RULE_13
    assign wr_stb   = i_chip_en & scl_fall & at_ack & (state_ff == lpr_pkg::DS_WR);  // RULE_04
    assign rd_inc   = i_chip_en & scl_rise & at_ack & (state_ff == lpr_pkg::DS_RD);  // RULE_13

    // read multiplexer, unmapped addresses read as zero
    always_comb begin
        rd_value = lpr_pkg::READ_UNMAPPED;
        if (ptr_ff == lpr_pkg::REG_CH1_PEAK) begin
            rd_value = peak_ff[0];
        end else if (ptr_ff == lpr_pkg::REG_CH2_PEAK) begin
            rd_value = peak_ff[1];
        end else if (ptr_ff == lpr_pkg::REG_CH3_PEAK) begin
            rd_value = peak_ff[2];
        end else if (ptr_ff == lpr_pkg::REG_ENABLE) begin
            rd_value = {2'h0, enable_ff};
        end else if (ptr_ff == lpr_pkg::REG_GLOBAL_DIM) begin
            rd_value = dim_ff;
        end
    end

    // bus protocol engine; data changes only while the clock line is low
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff   <= lpr_pkg::DS_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            rw_ff      <= 1'b0;
            sda_oe_ff  <= 1'b0;
        end else if (!i_chip_en) begin
            state_ff  <= lpr_pkg::DS_IDLE; // RULE_12
            sda_oe_ff <= 1'b0;             // RULE_12
        end else if (start_det) begin
            state_ff   <= lpr_pkg::DS_ADDR; // RULE_03
            bit_cnt_ff <= 4'h0;
            sda_oe_ff  <= 1'b0;
        end else if (stop_det) begin
            state_ff  <= lpr_pkg::DS_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (scl_rise && state_ff != lpr_pkg::DS_IDLE
                     && state_ff != lpr_pkg::DS_WAIT) begin
            if (bit_cnt_ff < lpr_pkg::BIT_ACK) begin
                // shifting in also walks the outgoing byte during reads
                shift_ff   <= {shift_ff[6:0], bus.sda};
                bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
            end else if (at_ack) begin
                bit_cnt_ff <= lpr_pkg::BIT_DONE;
                if (state_ff == lpr_pkg::DS_RD && bus.sda) begin
                    state_ff <= lpr_pkg::DS_WAIT; // RULE_02
                end
            end
        end else if (scl_fall) begin
            case (state_ff)
                lpr_pkg::DS_ADDR: begin
                    if (at_ack) begin
                        if (shift_ff[7:1] == lpr_pkg::TARGET_ADDR) begin
                            sda_oe_ff <= 1'b1;
                            rw_ff     <= shift_ff[0];
                        end else begin
                            state_ff <= lpr_pkg::DS_WAIT;
                        end
                    end else if (at_done) begin
                        bit_cnt_ff <= 4'h0;
                        if (rw_ff == lpr_pkg::RW_READ) begin
                            state_ff  <= lpr_pkg::DS_RD;
                            shift_ff  <= rd_value;     // RULE_01
                            sda_oe_ff <= ~rd_value[7]; // RULE_01
                        end else begin
                            state_ff  <= lpr_pkg::DS_REG;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                lpr_pkg::DS_REG, lpr_pkg::DS_WR: begin
                    if (at_ack) begin
                        sda_oe_ff <= 1'b1; // RULE_04
                    end else if (at_done) begin
                        sda_oe_ff  <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        state_ff   <= lpr_pkg::DS_WR;
                    end
                end
                lpr_pkg::DS_RD: begin
                    if (at_ack) begin
                        sda_oe_ff <= 1'b0; // release for the controller's answer
                    end else if (at_done) begin
                        // acknowledged: next higher register follows
                        shift_ff   <= rd_value;     // RULE_01
                        sda_oe_ff  <= ~rd_value[7];
                        bit_cnt_ff <= 4'h0;
                    end else if (bit_cnt_ff >= lpr_pkg::BIT_FIRST) begin
                        sda_oe_ff <= ~shift_ff[7];
                    end
                end
                default: begin
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // register pointer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ptr_ff <= lpr_pkg::PTR_RESET;
        end else if (reg_load) begin
            ptr_ff <= shift_ff; // RULE_13
        end else if (wr_stb || rd_inc) begin
            ptr_ff <= 8'(ptr_ff + 8'h01); // RULE_13
        end
    end

    // register writes; unmapped writes are dropped so the map stays sane
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            peak_ff   <= {lpr_pkg::PEAK_RESET, lpr_pkg::PEAK_RESET, lpr_pkg::PEAK_RESET};
            enable_ff <= lpr_pkg::ENABLE_RESET;
            dim_ff    <= lpr_pkg::DIM_RESET;
        end else if (wr_stb) begin
            if (ptr_ff == lpr_pkg::REG_CH1_PEAK) begin
                peak_ff[0] <= shift_ff; // RULE_05
            end else if (ptr_ff == lpr_pkg::REG_CH2_PEAK) begin
                peak_ff[1] <= shift_ff; // RULE_05
            end else if (ptr_ff == lpr_pkg::REG_CH3_PEAK) begin
                peak_ff[2] <= shift_ff; // RULE_05
            end else if (ptr_ff == lpr_pkg::REG_ENABLE) begin
                enable_ff <= shift_ff[5:0]; // RULE_06
            end else if (ptr_ff == lpr_pkg::REG_GLOBAL_DIM) begin
                dim_ff <= shift_ff;
            end
            // any other address is ignored // RULE_11
        end
    end

    // per channel effective duty; one global code applies to every output
    for (genvar c = 0; c < lpr_pkg::NUM_CH; c++) begin : g_ch
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                o_pwm_code[c] <= lpr_pkg::DUTY_ZERO;
            end else if (!enable_ff[lpr_pkg::EN_PWM_LSB + c * lpr_pkg::EN_STRIDE]) begin
                o_pwm_code[c] <= lpr_pkg::DUTY_ZERO; // RULE_07
            end else if (!i_dim_linear && dim_ff == lpr_pkg::DIM_OFF) begin // RULE_14
                o_pwm_code[c] <= lpr_pkg::DUTY_ZERO; // RULE_08
            end else if (dim_ff >= i_user_duty[c]) begin
                o_pwm_code[c] <= lpr_pkg::DUTY_ZERO; // RULE_10
            end else begin
                // code 00h subtracts nothing; same step for all channels
                o_pwm_code[c] <= 8'(i_user_duty[c] - dim_ff); // RULE_09
            end
        end
        assign o_pwm_enable[c]   = enable_ff[lpr_pkg::EN_PWM_LSB + c * lpr_pkg::EN_STRIDE];
        assign o_sense_enable[c] = enable_ff[lpr_pkg::EN_SENSE_LSB + c * lpr_pkg::EN_STRIDE];
    end

    assign o_peak_current = peak_ff;
    assign o_global_dim   = dim_ff;
    assign o_reg_ptr      = ptr_ff;
    assign bus.dev_sda_o  = 1'b0;
    assign bus.dev_sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// File: src/lpr_controller.sv
// controller end: issues write, current read and combined read transfers
`timescale 1ns/10ps
`default_nettype none
module lpr_controller (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    lpr_if.host                      bus,
    input  wire logic                i_req,
    input  wire logic [1:0]          i_op,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic [3:0]          i_count,
    input  wire logic [7:0]          i_wdata,
    output logic                     o_wdata_take,
    output logic      [7:0]          o_rdata,
    output logic                     o_rdata_valid,
    output logic                     o_busy,
    output logic                     o_nack
);
    lpr_pkg::lpr_host_state_e state_ff;
    logic [7:0] qcnt_ff;
    logic [1:0] phase_ff;
    logic       scl_ff;
    logic       oe_ff;
    logic [7:0] txb_ff;
    logic [7:0] rxb_ff;
    logic [3:0] bit_ff;
    logic [3:0] left_ff;
    logic [1:0] op_ff;
    logic [7:0] reg_ff;
    logic       rw_ff;
    logic       nack_ff;
    logic       tick;
    logic       is_tx;

    assign tick  = (qcnt_ff == lpr_pkg::QUARTER_LAST);
    assign is_tx = (state_ff == lpr_pkg::HS_ADDR) || (state_ff == lpr_pkg::HS_REG)
                   || (state_ff == lpr_pkg::HS_WDATA);

    // quarter bit timer; runs only inside a transfer
    always_ff @(posedge i_clk) begin
        if (i_rst || state_ff == lpr_pkg::HS_IDLE || tick) begin
            qcnt_ff <= 8'h00;
        end else begin
            qcnt_ff <= 8'(qcnt_ff + 8'h01);
        end
    end

    // transfer sequencer; each bit is four quarters: data, rise, sample, fall
    always_ff @(posedge i_clk) begin
        o_wdata_take  <= 1'b0;
        o_rdata_valid <= 1'b0;
        if (i_rst) begin
            state_ff <= lpr_pkg::HS_IDLE;
            phase_ff <= 2'h0;
            scl_ff   <= 1'b1;
            oe_ff    <= 1'b0;
            txb_ff   <= 8'h00;
            rxb_ff   <= 8'h00;
            bit_ff   <= 4'h0;
            left_ff  <= 4'h0;
            op_ff    <= lpr_pkg::OP_WRITE;
            reg_ff   <= 8'h00;
            rw_ff    <= 1'b0;
            nack_ff  <= 1'b0;
            o_rdata  <= 8'h00;
        end else if (state_ff == lpr_pkg::HS_IDLE) begin
            if (i_req) begin
                state_ff <= lpr_pkg::HS_START;
                phase_ff <= 2'h0;
                op_ff    <= i_op;
                reg_ff   <= i_reg_addr;
                left_ff  <= i_count;
                nack_ff  <= 1'b0;
                rw_ff    <= (i_op == lpr_pkg::OP_READ_CUR); // RULE_01
            end
        end else if (tick) begin
            phase_ff <= 2'(phase_ff + 2'h1);
            case (state_ff)
                lpr_pkg::HS_START, lpr_pkg::HS_RSTART: begin
                    case (phase_ff)
                        2'h0: oe_ff <= 1'b0;
                        2'h1: scl_ff <= 1'b1;
                        2'h2: oe_ff <= 1'b1;
                        default: begin
                            scl_ff   <= 1'b0;
                            bit_ff   <= 4'h0;
                            state_ff <= lpr_pkg::HS_ADDR;
                            if (state_ff == lpr_pkg::HS_RSTART) begin
                                rw_ff  <= lpr_pkg::RW_READ; // RULE_03
                                txb_ff <= {lpr_pkg::TARGET_ADDR, lpr_pkg::RW_READ};
                            end else begin
                                txb_ff <= {lpr_pkg::TARGET_ADDR, rw_ff};
                            end
                        end
                    endcase
                end
                lpr_pkg::HS_STOP: begin
                    case (phase_ff)
                        2'h0: oe_ff <= 1'b1;
                        2'h1: scl_ff <= 1'b1;
                        2'h2: oe_ff <= 1'b0;
                        default: state_ff <= lpr_pkg::HS_IDLE;
                    endcase
                end
                default: begin
                    case (phase_ff)
                        2'h0: begin
                            if (bit_ff == lpr_pkg::BIT_ACK) begin
                                // ack the byte unless it is the last one
                                oe_ff <= is_tx ? 1'b0 : (left_ff != 4'h1); // RULE_02
                            end else begin
                                oe_ff <= is_tx ? ~txb_ff[7] : 1'b0;
                            end
                        end
                        2'h1: scl_ff <= 1'b1;
                        2'h2: begin
                            if (bit_ff < lpr_pkg::BIT_ACK) begin
                                rxb_ff <= {rxb_ff[6:0], bus.sda};
                            end else if (is_tx && bus.sda) begin
                                nack_ff <= 1'b1;
                            end
                        end
                        default: begin
                            scl_ff <= 1'b0;
                            if (bit_ff < lpr_pkg::BIT_ACK) begin
                                bit_ff <= 4'(bit_ff + 4'h1);
                                txb_ff <= {txb_ff[6:0], 1'b0};
                            end else begin
                                bit_ff <= 4'h0;
                                if (is_tx && nack_ff) begin
                                    state_ff <= lpr_pkg::HS_STOP;
                                end else if (state_ff == lpr_pkg::HS_ADDR) begin
                                    if (rw_ff) begin
                                        state_ff <= lpr_pkg::HS_RDATA;
                                    end else begin
                                        state_ff <= lpr_pkg::HS_REG;
                                        txb_ff   <= reg_ff; // RULE_04
                                    end
                                end else if (state_ff == lpr_pkg::HS_REG) begin
                                    if (op_ff == lpr_pkg::OP_READ_AT) begin
                                        state_ff <= lpr_pkg::HS_RSTART; // RULE_03
                                    end else if (left_ff == 4'h0) begin
                                        state_ff <= lpr_pkg::HS_STOP;
                                    end else begin
                                        state_ff     <= lpr_pkg::HS_WDATA;
                                        txb_ff       <= i_wdata;
                                        o_wdata_take <= 1'b1;
                                    end
                                end else begin
                                    left_ff <= 4'(left_ff - 4'h1);
                                    if (state_ff == lpr_pkg::HS_RDATA) begin
                                        o_rdata       <= rxb_ff;
                                        o_rdata_valid <= 1'b1;
                                    end
                                    if (left_ff <= 4'h1) begin
                                        state_ff <= lpr_pkg::HS_STOP; // RULE_02
                                    end else if (state_ff == lpr_pkg::HS_WDATA) begin
                                        txb_ff       <= i_wdata; // RULE_04
                                        o_wdata_take <= 1'b1;
                                    end
                                end
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    assign o_busy          = (state_ff != lpr_pkg::HS_IDLE);
    assign o_nack          = nack_ff;
    assign bus.scl         = scl_ff;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_sda_oe = oe_ff;
endmodule
`default_nettype wire

// File: dv/lpr_link_asserts.sv
// wire level checks of the two wire register link
`timescale 1ns/10ps
`default_nettype none
module lpr_link_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // start and stop are the only data edges allowed while the clock is high
    sequence s_start; scl && $fell(sda); endsequence
    sequence s_stop; scl && $rose(sda); endsequence
    property p_rst_idle; $fell(i_rst) |-> scl && sda && !dev_sda_oe; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("link busy after reset");
    property p_scl_high; $rose(scl) |=> scl [*8]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("clock high too short");
    property p_scl_low; $fell(scl) |=> !scl [*8]; endproperty
    a_scl_low: assert property (p_scl_low) else $error("clock low too short");
    // target data may only move while the clock is low, else it fakes a start or a stop
    property p_dev_low; $changed(dev_sda_oe) |-> !scl; endproperty
    a_dev_low: assert property (p_dev_low) else $error("target moved data in clock high");
    property p_start_own; s_start |-> host_sda_oe && !dev_sda_oe; endproperty
    a_start_own: assert property (p_start_own) else $error("start not made by controller");
    property p_start_fall; s_start |=> scl [*8] ##[20:60] !scl; endproperty
    a_start_fall: assert property (p_start_fall) else $error("start hold wrong");
    property p_stop_idle; s_stop |-> !dev_sda_oe ##1 (scl && sda) [*8]; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("bus not free after stop");
    property p_host_mid; scl && $changed(host_sda_oe) |-> $past(scl, 8); endproperty
    a_host_mid: assert property (p_host_mid) else $error("controller data edge misplaced");
    // controller must have let go of data while the target answers in clock high
    property p_tied; scl && dev_sda_oe |-> !host_sda_oe; endproperty
    a_tied: assert property (p_tied) else $error("controller held data during target drive");
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench: controller and target joined over the link
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic             i_clk = 1'b0;
    logic             i_rst = 1'b1;
    logic             chip_en = 1'b1;
    logic             dim_lin = 1'b0;
    logic [2:0][7:0]  duty = {8'h10, 8'h23, 8'h40};
    logic             req = 1'b0;
    logic [1:0]       op = 2'h0;
    logic [7:0]       ra = 8'h00;
    logic [3:0]       cnt = 4'h0;
    logic [7:0]       wd = 8'h00;
    logic [7:0]       rd [5];
    logic [7:0]       z [5] = '{default: 8'h00};
    logic [2:0][7:0]  pwm;
    logic [2:0][7:0]  peak;
    logic [2:0]       pen;
    logic [2:0]       sen;
    logic [7:0]       gdim;
    logic [7:0]       ptr;
    logic [7:0]       rdata;
    logic             take;
    logic             rvalid;
    logic             busy;
    logic             nack;
    int               fails = 0;
    int               n_checks = 0;
    lpr_if bus ();
    lpr_target lpr_target_i (.i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_chip_en(chip_en),
        .i_dim_linear(dim_lin), .i_user_duty(duty), .o_pwm_code(pwm), .o_pwm_enable(pen),
        .o_sense_enable(sen), .o_peak_current(peak), .o_global_dim(gdim), .o_reg_ptr(ptr));
    lpr_controller lpr_controller_i (.i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_req(req),
        .i_op(op), .i_reg_addr(ra), .i_count(cnt), .i_wdata(wd), .o_wdata_take(take),
        .o_rdata(rdata), .o_rdata_valid(rvalid), .o_busy(busy), .o_nack(nack));
    lpr_link_asserts lpr_link_asserts_i (.i_clk(i_clk), .i_rst(i_rst), .scl(bus.scl),
        .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
        .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));
    // 20 MHz clock
    always #25 i_clk = ~i_clk;
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one transfer; next write byte shown after each take, bounded wait on busy
    task automatic xfer(input logic [1:0] o, input logic [7:0] a, input logic [3:0] n,
                        input logic [7:0] wq [5]);
        int k;
        int r;
        int t;
        k = 0;
        r = 0;
        @(negedge i_clk);
        op = o;
        ra = a;
        cnt = n;
        wd = wq[0];
        req = 1'b1;
        @(negedge i_clk);
        req = 1'b0;
        for (t = 0; t < 30000 && busy !== 1'b0; t++) begin
            @(negedge i_clk);
            if (take === 1'b1) begin
                k++;
                wd = wq[k % 5];
            end
            if (rvalid === 1'b1) begin
                rd[r % 5] = rdata;
                r++;
            end
        end
        if (t == 30000) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic t_burst();
        chk("ptr0", ptr, 8'h00);
        xfer(2'h0, 8'h00, 4'h5, '{8'h08, 8'h08, 8'h08, 8'h2a, 8'h23});
        for (int c = 0; c < 3; c++) chk("peak", peak[c], 8'h08);
        chk("pen", {5'h0, pen}, 8'h07);
        chk("sen", {5'h0, sen}, 8'h00);
        chk("dim", gdim, 8'h23);
        chk("ptr", ptr, 8'h05);
        chk("nack", {7'h0, nack}, 8'h00);
        $display("burst write done");
    endtask
    task automatic t_comb();
        xfer(2'h2, 8'h03, 4'h2, z);
        chk("rd0", rd[0], 8'h2a);
        chk("rd1", rd[1], 8'h23);
        $display("combined read done");
    endtask
    // both modes subtract the global code; equal code must give zero
    task automatic t_dim();
        for (int m = 0; m < 2; m++) begin
            @(negedge i_clk);
            dim_lin = m[0];
            repeat (2) @(negedge i_clk);
            chk("pwm0", pwm[0], 8'h1d);
            chk("pwm1", pwm[1], 8'h00);
            chk("pwm2", pwm[2], 8'h00);
        end
        $display("dimming modes done");
    endtask
    task automatic t_cur();
        xfer(2'h0, 8'h04, 4'h0, z);
        xfer(2'h1, 8'h00, 4'h1, z);
        chk("cur", rd[0], 8'h23);
        chk("ptr", ptr, 8'h05);
        $display("pointer read done");
    endtask
    task automatic t_mask();
        @(negedge i_clk);
        dim_lin = 1'b0;
        xfer(2'h0, 8'h04, 4'h1, '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00});
        chk("off", pwm[0], 8'h00);
        xfer(2'h0, 8'h03, 4'h2, '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00});
        chk("full", pwm[0], 8'h40);
        chk("masked", pwm[1], 8'h00);
        chk("pen", {5'h0, pen}, 8'h01);
        $display("off and mask done");
    endtask
    task automatic t_off();
        @(negedge i_clk);
        chip_en = 1'b0;
        xfer(2'h0, 8'h04, 4'h1, '{8'h55, 8'h00, 8'h00, 8'h00, 8'h00});
        chk("nack", {7'h0, nack}, 8'h01);
        chk("dim", gdim, 8'h00);
        chip_en = 1'b1;
        $display("chip disable done");
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        t_burst();
        t_comb();
        t_dim();
        t_cur();
        t_mask();
        t_off();
        end_of_test();
    end
endmodule
`default_nettype wire
